//--- verilog/sar_adc_sequencer.v
// Sequencer for an 8-bit successive-approximation converter
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "sar_adc_map.vh"
module sar_adc_sequencer
(
  sys_clk,
  rst,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  comp_in,
  ladder_tap,
  channel_sel,
  sample_en,
  hold_en,
  conv_busy,
  conversion_done_irq
);
  input  wire               sys_clk;
  input  wire               rst;
  input  wire               clk_en;
  input  wire [`ADDR_W-1:0] reg_addr;
  input  wire [`DATA_W-1:0] reg_wdata;
  input  wire               reg_wr;
  input  wire               reg_rd;
  output reg  [`DATA_W-1:0] reg_rdata;
  input  wire               comp_in;
  output wire [7:0]         ladder_tap;
  output reg  [2:0]         channel_sel;
  output reg                sample_en;
  output reg                hold_en;
  output reg                conv_busy;
  output reg                conversion_done_irq;

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_SAMPLE  = 2'h1;
  localparam [1:0] ST_CONVERT = 2'h2;
  localparam [7:0] MODE_RST   = `CONVERTER_MODE_RESET;
  localparam [7:0] CHAN_RST   = `INPUT_CHANNEL_RESET;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [3:0] phase_r;
  reg  [3:0] phase_nxt;
  reg  [3:0] step_cnt_r;
  reg  [3:0] step_cnt_nxt;

  reg        enable_r;
  reg  [2:0] time_code_r;
  reg  [2:0] chan_r;
  reg  [7:0] result_r;
  reg        first_pending_r;
  reg        first_result_r;

  reg  [3:0] step_len;
  reg        restart;
  reg        finish;
  reg        sar_clear;
  reg        sar_set_msb;
  reg        sar_resolve;

  wire       mode_wr;
  wire       chan_wr;
  wire       cfg_wr;
  wire       new_enable;
  wire       end_step;
  wire       comp_level;
  wire [7:0] sar_value;
  wire [2:0] bit_idx;
  wire [7:0] final_value;
  wire [7:0] mode_view;
  wire [7:0] chan_view;
  wire [7:0] status_view;

  // Configuration decode
  assign mode_wr    = reg_wr && (reg_addr == `CONVERTER_MODE_ADDR);
  assign chan_wr    = reg_wr && (reg_addr == `INPUT_CHANNEL_SEL_ADDR);
  assign cfg_wr     = mode_wr || chan_wr;
  assign new_enable = mode_wr ? reg_wdata[`MODE_ENABLE_BIT] : enable_r;

  // Comparator crosses in from the analog side
  pin_sync u_comp_sync
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (comp_in),
    .level_out (comp_level)
  );

  // Phases 4..11 map to bits 7..0
  assign bit_idx = 3'h7 - phase_r[2:0] + 3'h4;

  sar_bits u_sar
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .clear   (sar_clear),
    .set_msb (sar_set_msb),
    .resolve (sar_resolve),
    .bit_idx (bit_idx),
    .comp    (comp_level),
    .value   (sar_value)
  );

  // Ladder tap is the trial value register itself
  assign ladder_tap  = sar_value;
  assign final_value = {sar_value[7:1], comp_level};

  // Step length is one twelfth of the coded conversion time; the
  // prohibited short codes still run so a misprogram stays visible
  always @*
  begin
    case (time_code_r)
      `TIME_CODE_144: step_len = `STEP_CLKS_144;
      `TIME_CODE_120: step_len = `STEP_CLKS_120;
      `TIME_CODE_96:  step_len = `STEP_CLKS_96;
      `TIME_CODE_72:  step_len = `STEP_CLKS_72;
      `TIME_CODE_60:  step_len = `STEP_CLKS_60;
      `TIME_CODE_48:  step_len = `STEP_CLKS_48;
      default:        step_len = `STEP_CLKS_144;
    endcase
  end

  assign end_step = (state_r != ST_IDLE) &&
                    (step_cnt_r == step_len - 4'h1);

  // Sequencing
  always @*
  begin
    state_nxt    = state_r;
    phase_nxt    = phase_r;
    step_cnt_nxt = step_cnt_r;
    restart      = 1'b0;
    finish       = 1'b0;
    sar_clear    = 1'b0;
    sar_set_msb  = 1'b0;
    sar_resolve  = 1'b0;
    if (cfg_wr)
    begin
      // Write wins over any step, including the final one
      sar_clear    = 1'b1;
      phase_nxt    = 4'h0;
      step_cnt_nxt = 4'h0;
      if (new_enable)
      begin
        state_nxt = ST_SAMPLE;
        restart   = 1'b1;
      end
      else
        state_nxt = ST_IDLE;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          step_cnt_nxt = 4'h0;
          phase_nxt    = 4'h0;
        end
        ST_SAMPLE:
        begin
          if (end_step)
          begin
            step_cnt_nxt = 4'h0;
            phase_nxt    = phase_r + 4'h1;
            if (phase_r == `LAST_SAMPLE_PHASE)
            begin
              state_nxt   = ST_CONVERT;
              sar_set_msb = 1'b1;
            end
          end
          else
            step_cnt_nxt = step_cnt_r + 4'h1;
        end
        ST_CONVERT:
        begin
          if (end_step)
          begin
            sar_resolve  = 1'b1;
            step_cnt_nxt = 4'h0;
            if (phase_r == `LAST_PHASE)
            begin
              finish    = 1'b1;
              sar_clear = 1'b1;
              phase_nxt = 4'h0;
              state_nxt = ST_SAMPLE;
            end
            else
              phase_nxt = phase_r + 4'h1;
          end
          else
            step_cnt_nxt = step_cnt_r + 4'h1;
        end
        default:
        begin
          state_nxt    = ST_IDLE;
          phase_nxt    = 4'h0;
          step_cnt_nxt = 4'h0;
        end
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r    <= ST_IDLE;
      phase_r    <= 4'h0;
      step_cnt_r <= 4'h0;
    end
    else if (clk_en)
    begin
      state_r    <= state_nxt;
      phase_r    <= phase_nxt;
      step_cnt_r <= step_cnt_nxt;
    end
  end

  // Control registers
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      enable_r    <= MODE_RST[`MODE_ENABLE_BIT];
      time_code_r <= MODE_RST[`MODE_TIME_HI:`MODE_TIME_LO];
      chan_r      <= CHAN_RST[`CHAN_SEL_HI:`CHAN_SEL_LO];
    end
    else if (clk_en)
    begin
      if (mode_wr)
      begin
        enable_r    <= reg_wdata[`MODE_ENABLE_BIT];
        time_code_r <= reg_wdata[`MODE_TIME_HI:`MODE_TIME_LO];
      end
      if (chan_wr)
        chan_r <= reg_wdata[`CHAN_SEL_HI:`CHAN_SEL_LO];
    end
  end

  // Result has no reset so its power-up value is left undefined
  always @(posedge sys_clk)
  begin
    if (clk_en && finish)
      result_r <= final_value;
  end

  // Marks the first result after an enabling write as unreliable
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      first_pending_r <= 1'b0;
      first_result_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (restart)
        first_pending_r <= 1'b1;
      else if (finish)
        first_pending_r <= 1'b0;
      if (finish)
        first_result_r <= first_pending_r;
    end
  end

  // Analog-side controls, all registered
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      channel_sel         <= 3'h0;
      sample_en           <= 1'b0;
      hold_en             <= 1'b0;
      conv_busy           <= 1'b0;
      conversion_done_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      channel_sel         <= chan_wr ? reg_wdata[2:0] : chan_r;
      sample_en           <= (state_nxt == ST_SAMPLE);
      hold_en             <= (state_nxt == ST_CONVERT);
      conv_busy           <= (state_nxt != ST_IDLE);
      conversion_done_irq <= finish;
    end
  end

  // Register readback; reserved bits read as zero
  assign mode_view   = {enable_r, 1'b0, time_code_r, 3'h0};
  assign chan_view   = {5'h0, chan_r};
  assign status_view = {1'b0, bit_idx, 1'b0, first_result_r,
                        (state_r == ST_SAMPLE), (state_r != ST_IDLE)};

  // Read sees the register before this edge, so an update in the
  // same cycle lands only after the old result is returned
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      if (reg_rd)
      begin
        case (reg_addr)
          `CONVERTER_MODE_ADDR:    reg_rdata <= mode_view;
          `INPUT_CHANNEL_SEL_ADDR: reg_rdata <= chan_view;
          `CONVERSION_RESULT_ADDR: reg_rdata <= result_r;
          `CONVERTER_STATUS_ADDR:  reg_rdata <= status_view;
          default:                 reg_rdata <= 8'h00;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule // sar_adc_sequencer

//--- verilog/sar_adc_map.vh
// Register map, field positions and timing counts of the converter
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

`define ADDR_W            16
`define DATA_W            8

`define CONVERTER_MODE_ADDR     16'hff80
`define INPUT_CHANNEL_SEL_ADDR  16'hff84
`define CONVERSION_RESULT_ADDR  16'hff81
`define CONVERTER_STATUS_ADDR   16'hff82

`define CONVERTER_MODE_RESET    8'h00
`define INPUT_CHANNEL_RESET     8'h00

`define MODE_ENABLE_BIT   7
`define MODE_TIME_HI      5
`define MODE_TIME_LO      3
`define CHAN_SEL_HI       2
`define CHAN_SEL_LO       0

`define STAT_BUSY_BIT     0
`define STAT_SAMPLE_BIT   1
`define STAT_FIRST_BIT    2
`define STAT_IDX_HI       6
`define STAT_IDX_LO       4

`define TIME_CODE_144     3'h0
`define TIME_CODE_120     3'h1
`define TIME_CODE_96      3'h2
`define TIME_CODE_72      3'h4
`define TIME_CODE_60      3'h5
`define TIME_CODE_48      3'h6

`define CONV_CLKS_144     144
`define CONV_CLKS_120     120
`define CONV_CLKS_96      96
`define CONV_CLKS_72      72
`define CONV_CLKS_60      60
`define CONV_CLKS_48      48

`define STEP_CLKS_144     4'hc
`define STEP_CLKS_120     4'ha
`define STEP_CLKS_96      4'h8
`define STEP_CLKS_72      4'h6
`define STEP_CLKS_60      4'h5
`define STEP_CLKS_48      4'h4

`define STEPS_PER_CONV    12
`define SAMPLE_STEPS      4
`define LAST_PHASE        4'hb
`define LAST_SAMPLE_PHASE 4'h3

`endif

//--- verilog/pin_sync.v
// Three-stage synchroniser with agreement filter for an outside input
`timescale 1ns/1ps
module pin_sync
(
  sys_clk,
  rst,
  clk_en,
  pin_in,
  level_out
);
  input  wire sys_clk;
  input  wire rst;
  input  wire clk_en;
  input  wire pin_in;
  output reg  level_out;

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // First stage feeds only the second to keep metastability contained
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      level_out <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_out <= s3_r;
    end
  end
endmodule // pin_sync

//--- verilog/sar_bits.v
// Successive approximation register, one trial bit at a time
`timescale 1ns/1ps
module sar_bits
(
  sys_clk,
  rst,
  clk_en,
  clear,
  set_msb,
  resolve,
  bit_idx,
  comp,
  value
);
  input  wire       sys_clk;
  input  wire       rst;
  input  wire       clk_en;
  input  wire       clear;
  input  wire       set_msb;
  input  wire       resolve;
  input  wire [2:0] bit_idx;
  input  wire       comp;
  output reg  [7:0] value;

  wire [3:0] idx_ext;

  assign idx_ext = {1'b0, bit_idx};

  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1)
    begin : g_bit
      localparam [3:0] SELF = k;
      localparam [3:0] NEXT = k + 1;
      always @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          value[k] <= 1'b0;
        else if (clk_en)
        begin
          if (clear)
            value[k] <= 1'b0;
          else if (set_msb && (SELF == 4'h7))
            value[k] <= 1'b1;
          else if (resolve && (idx_ext == SELF))
            value[k] <= comp;
          else if (resolve && (idx_ext == NEXT))
            value[k] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule // sar_bits

//--- dv/sar_adc_sequencer_asserts.sv
// Port assertions for the converter sequencer
`timescale 1ns/1ps
`include "sar_adc_map.vh"
module sar_adc_sequencer_asserts
(
  input wire        sys_clk,
  input wire        rst,
  input wire        clk_en,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire [7:0]  ladder_tap,
  input wire [2:0]  channel_sel,
  input wire        sample_en,
  input wire        hold_en,
  input wire        conv_busy,
  input wire        conversion_done_irq
);
  wire      wr_ok = reg_wr && clk_en;
  wire      mode_wr = wr_ok && reg_addr == `CONVERTER_MODE_ADDR;
  wire      chan_wr = wr_ok && reg_addr == `INPUT_CHANNEL_SEL_ADDR;
  wire      cfg_wr = mode_wr || chan_wr;
  wire      mode_on = mode_wr && reg_wdata[7];
  wire      mode_off = mode_wr && !reg_wdata[7];
  reg [7:0] len_r;
  reg [7:0] cnt_r;
  reg       smp_r;
  // A restart inside the sample phase shows no rising edge, hence the clear
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      len_r <= 8'h00;
      cnt_r <= 8'h00;
      smp_r <= 1'b0;
    end
    else if (clk_en)
    begin
      smp_r <= sample_en;
      if (cfg_wr)
        cnt_r <= 8'h00;
      else if (sample_en && !smp_r)
        cnt_r <= 8'h01;
      else
        cnt_r <= cnt_r + 8'h01;
      // Prohibited codes are never written, so they fall to the default
      if (mode_wr)
        case (reg_wdata[5:3])
          3'h1:    len_r <= 8'h78;
          3'h2:    len_r <= 8'h60;
          3'h4:    len_r <= 8'h48;
          default: len_r <= 8'h90;
        endcase
    end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_sampling;
    (sample_en && !hold_en)[*8];
  endsequence
  sequence s_first_trial;
    $past(sample_en) && ladder_tap == 8'h80;
  endsequence
  property p_sw_start;
    $rose(conv_busy) |-> $past(mode_on);
  endproperty
  property p_enable;
    mode_on |=> sample_en && conv_busy && !hold_en;
  endproperty
  property p_stop;
    mode_off |=> !conv_busy && !sample_en && !hold_en;
  endproperty
  property p_sample;
    $rose(sample_en) |-> s_sampling;
  endproperty
  property p_first_trial;
    $rose(hold_en) |-> s_first_trial;
  endproperty
  property p_length;
    conversion_done_irq |-> cnt_r == len_r;
  endproperty
  property p_cfg_wins;
    cfg_wr |=> !conversion_done_irq;
  endproperty
  property p_chan;
    chan_wr |=> channel_sel == $past(reg_wdata[2:0]);
  endproperty
  property p_end;
    conversion_done_irq |-> $past(hold_en) && sample_en;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("busy without enable write");
  a_enable: assert property (p_enable)
    else $error("enable write did not start sampling");
  a_stop: assert property (p_stop)
    else $error("disable write did not stop");
  a_sample: assert property (p_sample)
    else $error("sample phase too short");
  a_first_trial: assert property (p_first_trial)
    else $error("first trial wrong");
  a_length: assert property (p_length)
    else $error("conversion length wrong");
  a_cfg_wins: assert property (p_cfg_wins)
    else $error("done request despite write");
  a_chan: assert property (p_chan)
    else $error("channel select wrong");
  a_end: assert property (p_end)
    else $error("done request out of place");
endmodule // sar_adc_sequencer_asserts

bind sar_adc_sequencer sar_adc_sequencer_asserts u_chk
(
  .sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .ladder_tap,
  .channel_sel, .sample_en, .hold_en, .conv_busy, .conversion_done_irq
);

//--- dv/analog_frontend_model.sv
// Sample-and-hold, ladder and comparator stand-in
`timescale 1ns/1ps
module analog_frontend_model
(
  input  wire        sys_clk,
  input  wire [47:0] levels,
  input  wire [2:0]  channel_sel,
  input  wire        sample_en,
  input  wire        hold_en,
  input  wire [7:0]  ladder_tap,
  output reg         comp_in
);
  reg [7:0] held_r;
  reg       junk_r = 1'b0;
  always @(posedge sys_clk)
  begin
    junk_r <= ~junk_r;
    if (sample_en)
      held_r <= levels[{channel_sel, 3'b000} +: 8];
  end
  // Outside hold the output means nothing, so it toggles
  always @*
    comp_in = hold_en ? (held_r >= ladder_tap) : junk_r;
endmodule // analog_frontend_model

//--- dv/sar_adc_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sar_adc_map.vh"
module sar_adc_sequencer_bench;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b1;
  reg         clk_en = 1'b1;
  reg  [15:0] reg_addr = 16'h0000;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [47:0] levels = 48'h0;
  wire [7:0]  reg_rdata;
  wire [7:0]  ladder_tap;
  wire [2:0]  channel_sel;
  wire        comp_in;
  wire        sample_en;
  wire        hold_en;
  wire        conv_busy;
  wire        irq;
  integer     err_count = 0;
  integer     checked = 0;
  integer     n;

  sar_adc_sequencer dut
  (
    .sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .comp_in, .ladder_tap, .channel_sel, .sample_en,
    .hold_en, .conv_busy, .conversion_done_irq (irq)
  );
  analog_frontend_model afe
  (
    .sys_clk, .levels, .channel_sel, .sample_en, .hold_en, .ladder_tap,
    .comp_in
  );

  initial
    forever #12.5 sys_clk = ~sys_clk;

  task test_done;
  begin
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  task chk(input string what, input [15:0] e, input [15:0] s);
  begin
    checked = checked + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  end
  endtask

  task wr(input [15:0] a, input [7:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  end
  endtask

  task rdc(input string what, input [15:0] a, input [7:0] e);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(what, {8'h00, e}, {8'h00, reg_rdata});
  end
  endtask

  // Counts edges up to the one that sees the done request
  task wirq;
  begin
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    while (irq !== 1'b1 && n < 400);
  end
  endtask

  task t_conv(input [2:0] code, input [2:0] ch, input [7:0] lvl,
              input [7:0] len);
  begin
    levels[{ch, 3'b000} +: 8] <= lvl;
    wr(`INPUT_CHANNEL_SEL_ADDR, {5'h00, ch});
    wr(`CONVERTER_MODE_ADDR, {2'b10, code, 3'b000});
    wirq;
    chk("first length", {8'h00, len}, n[15:0]);
    wirq;
    chk("next length", {8'h00, len}, n[15:0]);
    rdc("result", `CONVERSION_RESULT_ADDR, lvl);
    chk("channel", {13'h0, ch}, {13'h0, channel_sel});
  end
  endtask

  task t_abort;
  begin
    repeat (20) @(posedge sys_clk);
    wr(`CONVERTER_MODE_ADDR, 8'h20);
    chk("stop busy", 16'h0000, {15'h0, conv_busy});
    rdc("mode", `CONVERTER_MODE_ADDR, 8'h20);
    n = 0;
    repeat (200)
    begin
      @(posedge sys_clk);
      if (irq !== 1'b0)
        n = n + 1;
    end
    chk("idle irq", 16'h0000, n[15:0]);
    wr(`CONVERTER_MODE_ADDR, 8'ha0);
    repeat (30) @(posedge sys_clk);
    wr(`CONVERTER_MODE_ADDR, 8'ha0);
    wirq;
    chk("restart length", 16'h0048, n[15:0]);
    // A frozen enable must stretch the conversion by the frozen span
    clk_en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    clk_en <= 1'b1;
    wirq;
    chk("frozen length", 16'h0048, n[15:0]);
  end
  endtask

  // Strobes are timed to land on the edge that ends a conversion
  task t_race;
  begin
    wirq;
    levels[47:40] <= 8'h3c;
    repeat (70) @(posedge sys_clk);
    rdc("read at update", `CONVERSION_RESULT_ADDR, 8'ha5);
    rdc("after update", `CONVERSION_RESULT_ADDR, 8'h3c);
    wirq;
    levels[47:40] <= 8'h11;
    repeat (70) @(posedge sys_clk);
    wr(`CONVERTER_MODE_ADDR, 8'ha0);
    chk("irq at write", 16'h0000, {15'h0, irq});
    rdc("kept result", `CONVERSION_RESULT_ADDR, 8'h3c);
    // The read used two of the 72 cycles
    wirq;
    chk("after write", 16'h0046, n[15:0]);
  end
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc("mode reset", `CONVERTER_MODE_ADDR, 8'h00);
    rdc("channel reset", `INPUT_CHANNEL_SEL_ADDR, 8'h00);
    rdc("unmapped", 16'hff90, 8'h00);
    chk("idle busy", 16'h0000, {15'h0, conv_busy});
    t_conv(3'h0, 3'd0, 8'h00, 8'h90);
    t_conv(3'h1, 3'd1, 8'hff, 8'h78);
    t_conv(3'h2, 3'd2, 8'h80, 8'h60);
    t_conv(3'h4, 3'd3, 8'h7f, 8'h48);
    t_conv(3'h0, 3'd4, 8'h5a, 8'h90);
    t_conv(3'h4, 3'd5, 8'ha5, 8'h48);
    t_abort;
    t_race;
    test_done;
  end

  initial
  begin
    #(25 * 40000);
    err_count = err_count + 1;
    test_done;
  end
endmodule // sar_adc_sequencer_bench
